// file: inc/isr_ops_pkg.sv
/*
  Package for the indirect store and return execution unit: operation codes,
  pointer update modes, timing and reset values.
  Assumes a core that presents one decoded operation per instruction cycle.
*/
// Overview of operation
// - store writes working register to data address held in selected pointer
// - address is pointer+1, pointer-1 (pre modes), pointer (post modes), or pointer plus signed offset
// - pointer ends +1 for increments, -1 for decrements, unchanged for offset
// - mode 00 pre-inc, 01 pre-dec, 10 post-inc, 11 post-dec; one-bit pointer index
// - signed offset from -32 to +31 is added to pointer for address
// - pointers are 16 bits and wrap past either end
// - store and its pointer update change no status flag
// - option-load copies working register into option configuration register
// - software reset triggers full reset and clears the reset instruction flag
// - interrupt return pops stack into program counter, two cycles, no flags
// - interrupt return sets global interrupt enable, bit 7 of interrupt control
// - subroutine return pops stack into program counter, two cycles, no flags
package isr_ops_pkg;
  // ----------------------------------------------------------------
  // operations
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ISR_OP_IDLE = 3'h0,
    ISR_OP_STORE = 3'h1,
    ISR_OP_OPTION = 3'h2,
    ISR_OP_RESET = 3'h3,
    ISR_OP_RETINT = 3'h4,
    ISR_OP_RETSUB = 3'h5
  } isr_op_t;

  // ----------------------------------------------------------------
  // pointer update modes, offset store uses a separate flag
  // ----------------------------------------------------------------
  localparam logic [1:0] MODE_PRE_INC = 2'h0;
  localparam logic [1:0] MODE_PRE_DEC = 2'h1;
  localparam logic [1:0] MODE_POST_INC = 2'h2;
  localparam logic [1:0] MODE_POST_DEC = 2'h3;

  localparam int PTR_W = 16;
  localparam int PC_W = 11;
  localparam int OFS_W = 6;
  localparam int GIE_BIT = 7;
  localparam int RET_CYCLES = 2;
  localparam logic [PTR_W-1:0] PTR_RESET = 16'h0000;
  localparam logic [7:0] OPTION_RESET = 8'hff;
  localparam logic [7:0] INTCTL_RESET = 8'h00;
endpackage

// file: rtl/isr_ptr_unit.sv
/*
  Address and pointer update arithmetic for the indirect store.
  Purely combinational; the caller registers the results.
*/
`timescale 1ns/100ps
module isr_ptr_unit
  import isr_ops_pkg::*;
(
  // operands
  input wire logic [isr_ops_pkg::PTR_W-1:0] ptr,
  input wire logic [1:0] pointer_update_mode,
  input wire logic use_offset,
  input wire logic [isr_ops_pkg::OFS_W-1:0] offset,
  // results
  output logic [isr_ops_pkg::PTR_W-1:0] eff_addr,
  output logic [isr_ops_pkg::PTR_W-1:0] ptr_after
);
  logic [PTR_W-1:0] plus1;
  logic [PTR_W-1:0] minus1;
  logic [PTR_W-1:0] sext;

  // 16-bit sums drop the carry, so both ends wrap naturally
  assign plus1 = ptr + 16'h0001;
  assign minus1 = ptr - 16'h0001;
  assign sext = {{(PTR_W-OFS_W){offset[OFS_W-1]}}, offset};

  // effective address and updated pointer per mode
  always_comb
  begin
    eff_addr = ptr;
    ptr_after = ptr;
    if (use_offset)
    begin
      eff_addr = ptr + sext;
      ptr_after = ptr;
    end
    else
    begin
      unique case (pointer_update_mode)
        MODE_PRE_INC:
        begin
          eff_addr = plus1;
          ptr_after = plus1;
        end
        MODE_PRE_DEC:
        begin
          eff_addr = minus1;
          ptr_after = minus1;
        end
        MODE_POST_INC:
        begin
          eff_addr = ptr;
          ptr_after = plus1;
        end
        MODE_POST_DEC:
        begin
          eff_addr = ptr;
          ptr_after = minus1;
        end
      endcase
    end
  end
endmodule // isr_ptr_unit

// file: rtl/isr_ops_core.sv
/*
  Execution unit for indirect store, option load, software reset, idle and
  returns. Decoded ops arrive as a one-cycle op_valid with fields; data memory
  write, stack pop and reset request leave as strobes.
  Assumes the stack delivers stack_top combinationally and that the device
  reset network feeds reset back after soft_reset_req.
*/
`timescale 1ns/100ps
module isr_ops_core
  import isr_ops_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // decoded instruction
  input wire logic op_valid,
  input wire isr_ops_pkg::isr_op_t op_code,
  input wire logic ptr_sel,
  input wire logic [1:0] pointer_update_mode,
  input wire logic use_offset,
  input wire logic [isr_ops_pkg::OFS_W-1:0] offset,
  input wire logic [7:0] w_reg,
  input wire logic [isr_ops_pkg::PC_W-1:0] stack_top,
  input wire logic por_event,
  // core state outputs
  output logic busy,
  output logic [isr_ops_pkg::PC_W-1:0] pc_r,
  output logic [isr_ops_pkg::PTR_W-1:0] ptr0_r,
  output logic [isr_ops_pkg::PTR_W-1:0] ptr1_r,
  output logic [7:0] option_reg_r,
  output logic [7:0] interrupt_control_reg_r,
  output logic reset_instr_flag_r,
  output logic [7:0] status_r,
  // data memory and stack
  output logic mem_we_r,
  output logic [isr_ops_pkg::PTR_W-1:0] mem_addr_r,
  output logic [7:0] mem_wdata_r,
  output logic stack_pop,
  output logic soft_reset_req_r
);
  // ----------------------------------------------------------------
  // sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_RUN = 2'b01,
    ST_RET2 = 2'b10
  } isr_state_t;

  isr_state_t state_r, state_nxt;
  logic [PC_W-1:0] pc_nxt;
  logic [PTR_W-1:0] ptr0_nxt, ptr1_nxt, sel_ptr, eff_addr, ptr_after;
  logic [7:0] option_nxt, intctl_nxt;
  logic mem_we_nxt, soft_nxt, take;
  logic [PTR_W-1:0] mem_addr_nxt;
  logic [7:0] mem_wdata_nxt;

  assign take = op_valid && (state_r == ST_RUN);
  assign busy = (state_r == ST_RET2); // second return cycle refuses ops
  assign sel_ptr = ptr_sel ? ptr1_r : ptr0_r;
  // the indirect window is only an address path, never stored
  isr_ptr_unit u_ptr (
    .ptr(sel_ptr),
    .pointer_update_mode(pointer_update_mode),
    .use_offset(use_offset),
    .offset(offset),
    .eff_addr(eff_addr),
    .ptr_after(ptr_after)
  );

  // pop happens in the first return cycle, pc loads in the second
  assign stack_pop = take && (op_code == ISR_OP_RETINT || op_code == ISR_OP_RETSUB);

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    state_nxt = state_r;
    pc_nxt = pc_r;
    ptr0_nxt = ptr0_r;
    ptr1_nxt = ptr1_r;
    option_nxt = option_reg_r;
    intctl_nxt = interrupt_control_reg_r;
    mem_we_nxt = 1'b0;
    mem_addr_nxt = mem_addr_r;
    mem_wdata_nxt = mem_wdata_r;
    soft_nxt = 1'b0;
    unique case (state_r)
      ST_RUN:
      begin
        if (take)
        begin
          pc_nxt = pc_r + 11'h001;
          unique case (op_code)
            ISR_OP_STORE:
            begin
              mem_we_nxt = 1'b1;
              mem_addr_nxt = eff_addr;
              mem_wdata_nxt = w_reg;
              if (ptr_sel)
                ptr1_nxt = ptr_after;
              else
                ptr0_nxt = ptr_after;
            end
            ISR_OP_OPTION: option_nxt = w_reg;
            ISR_OP_RESET: soft_nxt = 1'b1;
            ISR_OP_RETINT:
            begin
              pc_nxt = pc_r;
              intctl_nxt[GIE_BIT] = 1'b1;
              state_nxt = ST_RET2;
            end
            ISR_OP_RETSUB:
            begin
              pc_nxt = pc_r;
              state_nxt = ST_RET2;
            end
            default: ;
          endcase
        end
      end
      ST_RET2:
      begin
        pc_nxt = stack_top;
        state_nxt = ST_RUN;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // registers; status is held constant since no op here touches flags
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      state_r <= ST_RUN;
      pc_r <= '0;
      ptr0_r <= PTR_RESET;
      ptr1_r <= PTR_RESET;
      option_reg_r <= OPTION_RESET;
      interrupt_control_reg_r <= INTCTL_RESET;
      mem_we_r <= 1'b0;
      mem_addr_r <= '0;
      mem_wdata_r <= 8'h00;
      soft_reset_req_r <= 1'b0;
      status_r <= 8'h00;
    end
    else
    begin
      state_r <= state_nxt;
      pc_r <= pc_nxt;
      ptr0_r <= ptr0_nxt;
      ptr1_r <= ptr1_nxt;
      option_reg_r <= option_nxt;
      interrupt_control_reg_r <= intctl_nxt;
      mem_we_r <= mem_we_nxt;
      mem_addr_r <= mem_addr_nxt;
      mem_wdata_r <= mem_wdata_nxt;
      soft_reset_req_r <= soft_nxt;
      status_r <= status_r;
    end
  end

  // flag survives the reset it causes: cleared by the op, set by power-on
  always_ff @(posedge clk_sys)
  begin
    if (por_event)
      reset_instr_flag_r <= 1'b1;
    else if (take && op_code == ISR_OP_RESET)
      reset_instr_flag_r <= 1'b0;
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence ret_start_s;
    take && (op_code == ISR_OP_RETINT || op_code == ISR_OP_RETSUB);
  endsequence
  sequence ret_load_s;
    busy ##1 (pc_r == $past(stack_top) && !busy);
  endsequence

  store_write_a: assert property (@(posedge clk_sys) disable iff (reset)
    take && op_code == ISR_OP_STORE |=> mem_we_r && mem_wdata_r == $past(w_reg))
    else $error("store did not write working register");
  pre_inc_a: assert property (@(posedge clk_sys) disable iff (reset)
    take && op_code == ISR_OP_STORE && !use_offset && pointer_update_mode == MODE_PRE_INC
    |=> mem_addr_r == $past(sel_ptr) + 16'h0001)
    else $error("pre-increment address wrong");
  offset_keep_a: assert property (@(posedge clk_sys) disable iff (reset)
    take && op_code == ISR_OP_STORE && use_offset && !ptr_sel |=> $stable(ptr0_r))
    else $error("offset store moved pointer");
  post_dec_a: assert property (@(posedge clk_sys) disable iff (reset)
    take && op_code == ISR_OP_STORE && !use_offset && pointer_update_mode == MODE_POST_DEC
    && ptr_sel |=> mem_addr_r == $past(ptr1_r) && ptr1_r == $past(ptr1_r) - 16'h0001)
    else $error("post-decrement wrong");
  offset_addr_a: assert property (@(posedge clk_sys) disable iff (reset)
    take && op_code == ISR_OP_STORE && use_offset && offset == 6'h20
    |=> mem_addr_r == $past(sel_ptr) - 16'h0020)
    else $error("offset -32 address wrong");
  ptr_wrap_a: assert property (@(posedge clk_sys) disable iff (reset)
    take && op_code == ISR_OP_STORE && !use_offset && !ptr_sel && ptr0_r == 16'hffff
    && pointer_update_mode == MODE_POST_INC |=> ptr0_r == 16'h0000)
    else $error("pointer did not wrap");
  status_hold_a: assert property (@(posedge clk_sys) disable iff (reset)
    take && op_code == ISR_OP_STORE |=> $stable(status_r))
    else $error("store changed status");
  option_load_a: assert property (@(posedge clk_sys) disable iff (reset)
    take && op_code == ISR_OP_OPTION |=> option_reg_r == $past(w_reg))
    else $error("option not loaded");
  soft_reset_a: assert property (@(posedge clk_sys) disable iff (reset)
    take && op_code == ISR_OP_RESET && !por_event |=> soft_reset_req_r && !reset_instr_flag_r)
    else $error("software reset wrong");
  ret_timing_a: assert property (@(posedge clk_sys) disable iff (reset)
    ret_start_s |=> ret_load_s)
    else $error("return not two cycles");
  gie_set_a: assert property (@(posedge clk_sys) disable iff (reset)
    take && op_code == ISR_OP_RETINT |=> interrupt_control_reg_r[GIE_BIT])
    else $error("interrupt enable not set");
  retsub_gie_a: assert property (@(posedge clk_sys) disable iff (reset)
    take && op_code == ISR_OP_RETSUB |=> $stable(interrupt_control_reg_r))
    else $error("subroutine return touched interrupt control");
  idle_op_a: assert property (@(posedge clk_sys) disable iff (reset)
    take && op_code == ISR_OP_IDLE |=> pc_r == $past(pc_r) + 11'h001 && !mem_we_r
    && $stable(ptr0_r) && $stable(ptr1_r))
    else $error("idle op changed state");
endmodule // isr_ops_core

// file: sim/isr_ops_bench.sv
/*
  Self-checking bench for the indirect store and return execution unit.
  Assumes isr_ops_pkg is compiled first; the bench stands in for decode and stack.
*/
`timescale 1ns/100ps
module isr_ops_bench;
  import isr_ops_pkg::*;
  // ----------------------------------------------------------------
  // signals and store table
  // ----------------------------------------------------------------
  typedef struct {
    logic sel;
    logic [1:0] mode;
    logic ofs_en;
    logic [5:0] ofs;
    logic [7:0] w;
    logic [15:0] addr;
    logic [15:0] p0;
    logic [15:0] p1;
  } isr_row_t;
  logic clk_sys, reset, op_valid, ptr_sel, use_offset, por_event;
  isr_op_t op_code;
  logic [1:0] pointer_update_mode;
  logic [OFS_W-1:0] offset;
  logic [7:0] w_reg;
  logic [PC_W-1:0] stack_top, exp_pc;
  logic busy, reset_instr_flag_r, mem_we_r, stack_pop, soft_reset_req_r;
  logic [PC_W-1:0] pc_r;
  logic [PTR_W-1:0] ptr0_r, ptr1_r, mem_addr_r;
  logic [7:0] option_reg_r, interrupt_control_reg_r, status_r, mem_wdata_r;
  int err_count = 0;
  int tests_run = 0;
  int cycles = 0;
  // pointers start at zero; rows run back to back and hit both wrap ends
  isr_row_t rows [9] = '{
    '{1'b0, 2'h0, 1'b0, 6'h00, 8'h11, 16'h0001, 16'h0001, 16'h0000},
    '{1'b0, 2'h1, 1'b0, 6'h00, 8'h22, 16'h0000, 16'h0000, 16'h0000},
    '{1'b0, 2'h3, 1'b0, 6'h00, 8'h33, 16'h0000, 16'hffff, 16'h0000},
    '{1'b0, 2'h2, 1'b0, 6'h00, 8'h44, 16'hffff, 16'h0000, 16'h0000},
    '{1'b1, 2'h1, 1'b0, 6'h00, 8'h55, 16'hffff, 16'h0000, 16'hffff},
    '{1'b1, 2'h0, 1'b0, 6'h00, 8'h66, 16'h0000, 16'h0000, 16'h0000},
    '{1'b1, 2'h0, 1'b1, 6'h20, 8'h77, 16'hffe0, 16'h0000, 16'h0000},
    '{1'b0, 2'h1, 1'b1, 6'h1f, 8'h88, 16'h001f, 16'h0000, 16'h0000},
    '{1'b1, 2'h2, 1'b0, 6'h00, 8'h99, 16'h0000, 16'h0000, 16'h0001}};

  isr_ops_core i_isr_ops_core (.clk_sys(clk_sys), .reset(reset), .op_valid(op_valid),
    .op_code(op_code), .ptr_sel(ptr_sel), .pointer_update_mode(pointer_update_mode),
    .use_offset(use_offset), .offset(offset), .w_reg(w_reg), .stack_top(stack_top),
    .por_event(por_event), .busy(busy), .pc_r(pc_r), .ptr0_r(ptr0_r), .ptr1_r(ptr1_r),
    .option_reg_r(option_reg_r), .interrupt_control_reg_r(interrupt_control_reg_r),
    .reset_instr_flag_r(reset_instr_flag_r), .status_r(status_r), .mem_we_r(mem_we_r),
    .mem_addr_r(mem_addr_r), .mem_wdata_r(mem_wdata_r), .stack_pop(stack_pop),
    .soft_reset_req_r(soft_reset_req_r));

  // ----------------------------------------------------------------
  // clock, hang guard and shared tasks
  // ----------------------------------------------------------------
  initial
  begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  // whole run is about 27 cycles; the ceiling leaves ample margin
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles > 2000)
    begin
      err_count++;
      report_and_stop();
    end
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // inputs move 1 ns after the edge so sampling never races the drive
  task automatic tick();
    @(posedge clk_sys);
    #1;
  endtask
  task automatic drive(input isr_op_t op, input logic [7:0] w);
    op_valid = 1'b1;
    op_code = op;
    w_reg = w;
  endtask
  task automatic check_reset_state();
    check("pc", pc_r, 0);
    check("ptr0", ptr0_r, 0);
    check("ptr1", ptr1_r, 0);
    check("option", option_reg_r, OPTION_RESET);
    check("intctl", interrupt_control_reg_r, 0);
    check("busy", busy, 0);
    check("strobes", {mem_we_r, soft_reset_req_r}, 0);
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    reset = 1'b1;
    op_valid = 1'b0;
    op_code = ISR_OP_IDLE;
    ptr_sel = 1'b0;
    pointer_update_mode = 2'h0;
    use_offset = 1'b0;
    offset = 6'h00;
    w_reg = 8'h00;
    stack_top = 11'h000;
    por_event = 1'b0;
    repeat (6) @(posedge clk_sys);
    #1;
    check_reset_state();
    reset = 1'b0;
    por_event = 1'b1;
    tick();
    por_event = 1'b0;
    check("flag set", reset_instr_flag_r, 1);
    $display("test reset done");
    // stores issued on consecutive cycles, results seen one cycle later
    exp_pc = 11'h000;
    for (int i = 0; i < 9; i++)
    begin
      ptr_sel = rows[i].sel;
      pointer_update_mode = rows[i].mode;
      use_offset = rows[i].ofs_en;
      offset = rows[i].ofs;
      drive(ISR_OP_STORE, rows[i].w);
      tick();
      exp_pc = exp_pc + 11'h001;
      check("we", mem_we_r, 1);
      check("addr", mem_addr_r, rows[i].addr);
      check("wdata", mem_wdata_r, rows[i].w);
      check("ptr0", ptr0_r, rows[i].p0);
      check("ptr1", ptr1_r, rows[i].p1);
      check("status", status_r, 0);
      check("pc", pc_r, exp_pc);
    end
    $display("test stores done");
    drive(ISR_OP_IDLE, 8'h00);
    tick();
    check("idle pc", pc_r, exp_pc + 11'h001);
    check("idle we", mem_we_r, 0);
    check("idle ptr", {ptr0_r, ptr1_r}, 32'h0000_0001);
    check("idle option", option_reg_r, OPTION_RESET);
    drive(ISR_OP_OPTION, 8'h5a);
    // op stays presented until the next drive in this same time step replaces it
    tick();
    check("option", option_reg_r, 8'h5a);
    check("option we", mem_we_r, 0);
    $display("test idle and option done");
    // subroutine return then interrupt return; a store during busy is dropped
    for (int k = 0; k < 2; k++)
    begin
      stack_top = (k == 0) ? 11'h123 : 11'h7fe;
      drive((k == 0) ? ISR_OP_RETSUB : ISR_OP_RETINT, 8'h00);
      #1;
      check("pop", stack_pop, 1);
      tick();
      drive(ISR_OP_STORE, 8'h3c);
      #1;
      check("busy", busy, 1);
      check("single pop", stack_pop, 0);
      check("gie", interrupt_control_reg_r[GIE_BIT], k);
      // no release here: the next drive retargets op_valid once in this step
      tick();
      check("ret pc", pc_r, stack_top);
      check("busy end", busy, 0);
      check("refused", mem_we_r, 0);
      check("ret status", status_r, 0);
    end
    $display("test returns done");
    drive(ISR_OP_RESET, 8'h00);
    tick();
    op_valid = 1'b0;
    check("reset req", soft_reset_req_r, 1);
    check("flag clear", reset_instr_flag_r, 0);
    check("reset status", status_r, 0);
    tick();
    check("req pulse", soft_reset_req_r, 0);
    // the device reset that follows must not restore the cause flag
    reset = 1'b1;
    tick();
    tick();
    check_reset_state();
    reset = 1'b0;
    tick();
    check("flag kept", reset_instr_flag_r, 0);
    $display("test software reset done");
    report_and_stop();
  end
endmodule // isr_ops_bench
